// >>> hdl/mmd_pkg.sv
// constants shared by the indirect register portal and its management frame slave
package mmd_pkg;

	// ----------------------------------------------------------------
	// direct management register offsets
	// ----------------------------------------------------------------
	localparam logic [4:0] REG_MMD_CONTROL = 5'h0D;
	localparam logic [4:0] REG_MMD_DATA = 5'h0E;

	// ----------------------------------------------------------------
	// portal control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_OP_MSB = 15;
	localparam int CTRL_OP_LSB = 14;
	localparam int CTRL_RSV_MSB = 13;
	localparam int CTRL_RSV_LSB = 5;
	localparam int CTRL_DEV_MSB = 4;
	localparam logic [1:0] OP_REGISTER = 2'h0;
	localparam logic [1:0] OP_DATA_HOLD = 2'h1;
	localparam logic [1:0] OP_DATA_INC_RW = 2'h2;
	localparam logic [1:0] OP_DATA_INC_WR = 2'h3;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] PORTAL_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// indirect spaces and registers
	// ----------------------------------------------------------------
	localparam logic [4:0] DEV_LINE_SIDE = 5'h01;
	localparam logic [4:0] DEV_WAKE = 5'h1F;
	localparam logic [15:0] LINE_CONTROL_ONE = 16'h0000;
	localparam logic [15:0] LINE_STATUS_ONE = 16'h0001;
	localparam logic [15:0] WAKE_CONTROL = 16'h0000;
	localparam logic [15:0] WAKE_STATION_FIRST = 16'h0019;
	localparam logic [15:0] WAKE_STATION_LAST = 16'h001B;
	localparam int IDLE_ENABLE_BIT = 12;
	localparam int IDLE_LATCHED_BIT = 8;
	localparam int WAKE_LINK_UP_BIT = 0;
	localparam logic [15:0] WAKE_RESET = 16'h0000;

	// ----------------------------------------------------------------
	// management frame layout
	// ----------------------------------------------------------------
	localparam logic [1:0] FRAME_OP_READ = 2'h2;
	localparam logic [1:0] FRAME_OP_WRITE = 2'h1;
	localparam logic [4:0] FRAME_HDR_LAST = 5'h0C;
	localparam logic [4:0] FRAME_TA_BITS = 5'h02;
	localparam logic [4:0] FRAME_TAIL_LAST = 5'h11;
	localparam logic [4:0] FRAME_RD_RELEASE = 5'h12;

endpackage

// >>> hdl/mgmt_frame_slave.sv
// serial management frame slave: samples the management clock and data pin
`timescale 1ns/1ps
module mgmt_frame_slave #(
	parameter logic [4:0] PHY_ADDR = 5'h00
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic mdio_in,
	input wire logic [15:0] rd_data,
	output logic [4:0] reg_addr,
	output logic [15:0] wr_data,
	output logic wr_stb,
	output logic rd_stb,
	output logic mdio_out,
	output logic mdio_oe
);

	typedef enum logic [1:0] {S_IDLE, S_HDR, S_WRITE, S_READ} frame_state_t;

	frame_state_t state;
	logic mdc_s1, mdc_s2, mdc_s3;
	logic mdio_s1, mdio_s2;
	logic prev_one;
	logic do_write;
	logic [4:0] cnt;
	logic [11:0] hdr;
	logic [12:0] next_hdr;
	logic [15:0] shift;
	logic rise, fall;

	// ----------------------------------------------------------------
	// pin synchronisers and clock edge detection
	// ----------------------------------------------------------------
	// first stages feed only the second stages
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			mdc_s1 <= 1'b0;
			mdc_s2 <= 1'b0;
			mdc_s3 <= 1'b0;
			mdio_s1 <= 1'b1;
			mdio_s2 <= 1'b1;
		end else begin
			mdc_s1 <= mdc;
			mdc_s2 <= mdc_s1;
			mdc_s3 <= mdc_s2;
			mdio_s1 <= mdio_in;
			mdio_s2 <= mdio_s1;
		end
	end

	assign rise = mdc_s2 & ~mdc_s3;
	assign fall = ~mdc_s2 & mdc_s3;
	assign next_hdr = {hdr, mdio_s2};

	// ----------------------------------------------------------------
	// frame sequencer
	// ----------------------------------------------------------------
	// frames for another address are walked through so they are never mistaken for a start
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state <= S_IDLE;
			cnt <= 5'h00;
			hdr <= 12'h000;
			prev_one <= 1'b0;
			do_write <= 1'b0;
			reg_addr <= 5'h00;
			wr_data <= 16'h0000;
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
		end else begin
			wr_stb <= 1'b0;
			rd_stb <= 1'b0;
			unique case (state)
				S_IDLE: if (rise) begin
					prev_one <= mdio_s2;
					if (!mdio_s2 && prev_one) begin
						state <= S_HDR;
						cnt <= 5'h00;
					end
				end
				S_HDR: if (rise) begin
					hdr <= next_hdr[11:0];
					cnt <= cnt + 5'h01;
					if (cnt == mmd_pkg::FRAME_HDR_LAST) begin
						cnt <= 5'h00;
						reg_addr <= next_hdr[4:0];
						if (next_hdr[12] && next_hdr[9:5] == PHY_ADDR && next_hdr[11:10] == mmd_pkg::FRAME_OP_READ) begin
							rd_stb <= 1'b1;
							state <= S_READ;
						end else begin
							do_write <= next_hdr[12] && next_hdr[9:5] == PHY_ADDR
								&& next_hdr[11:10] == mmd_pkg::FRAME_OP_WRITE;
							state <= S_WRITE;
						end
					end
				end
				S_WRITE: if (rise) begin
					cnt <= cnt + 5'h01;
					if (cnt >= mmd_pkg::FRAME_TA_BITS) begin
						wr_data <= {wr_data[14:0], mdio_s2};
					end
					if (cnt == mmd_pkg::FRAME_TAIL_LAST) begin
						wr_stb <= do_write;
						prev_one <= 1'b0;
						state <= S_IDLE;
					end
				end
				S_READ: if (fall) begin
					cnt <= cnt + 5'h01;
					if (cnt == mmd_pkg::FRAME_RD_RELEASE) begin
						prev_one <= 1'b0;
						state <= S_IDLE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// read data drive
	// ----------------------------------------------------------------
	// data changes on falling edges so the far end samples it stable on rising ones
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			shift <= 16'h0000;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
		end else if (rd_stb) begin
			shift <= rd_data;
		end else if (state == S_READ && fall) begin
			if (cnt == 5'h00) begin
				mdio_oe <= 1'b0;
			end else if (cnt == 5'h01) begin
				mdio_oe <= 1'b1;
				mdio_out <= 1'b0;
			end else if (cnt <= mmd_pkg::FRAME_TAIL_LAST) begin
				mdio_out <= shift[15];
				shift <= {shift[14:0], 1'b0};
			end else begin
				mdio_oe <= 1'b0;
			end
		end else if (state != S_READ) begin
			mdio_oe <= 1'b0;
		end
	end

endmodule

// >>> hdl/mmd_indirect_portal.sv
// indirect register portal reached through the serial management frames
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// (R01) thirty-two indirect spaces of 65536 words, reached only through two portal registers
// (R02) control bits 4:0 choose the indirect space used by data port accesses
// (R03) control bits 15:14 choose address mode 00 or one of three data modes
// (R04) in mode 00 the data port stores and returns the target register address
// (R05) in data modes the data port reads or writes the selected indirect register
// (R06) mode 01 leaves the target address unchanged after data port reads and writes
// (R07) mode 10 advances the target address after every data port read and write
// (R08) mode 11 advances the target address after writes only, never after reads
// (R09) manager sets device, writes address in mode 00, switches to data mode, writes value
// (R10) burst reads in mode 10 return consecutive registers, one per data port read
// (R11) writing 0001h to space 1Fh register 0 enables link-up as wake event trigger
// (R12) space 1Fh registers 19h to 1Bh hold the three wake station address words
// (R13) space 1 register 0 bit 12 is the low power idle enable, reset to 0
// (R14) space 1 register 1 bit 8 latches high on idle entry and clears when read
// (R15) unimplemented spaces and registers read as zero and ignore writes
// ----------------------------------------------------------------
module mmd_indirect_portal #(
	parameter logic [4:0] PHY_ADDR = 5'h00
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic mdc,
	input wire logic mdio_in,
	input wire logic low_power_idle_state_in,
	output logic mdio_out,
	output logic mdio_oe,
	output logic low_power_idle_enable,
	output logic wake_link_up_enable
);

	logic [4:0] reg_addr;
	logic [15:0] wr_data;
	logic wr_stb;
	logic rd_stb;
	logic [15:0] rd_data;
	logic [15:0] mmd_data;

	logic [1:0] ctrl_op;
	logic [8:0] ctrl_rsv;
	logic [4:0] ctrl_dev;
	logic [15:0] portal_addr;
	logic [15:0] wake_ctrl;
	logic [15:0] station_word [0:2];
	logic low_power_idle_latched;
	logic idle_s1, idle_s2;

	logic ctrl_wr, data_wr, data_rd, data_mode, advance;
	logic ind_wr, ind_rd;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// station words sit in a short window of consecutive indirect addresses
	function automatic logic station_hit(input logic [15:0] addr);
		station_hit = addr >= mmd_pkg::WAKE_STATION_FIRST && addr <= mmd_pkg::WAKE_STATION_LAST;
	endfunction

	function automatic logic [1:0] station_index(input logic [15:0] addr);
		logic [15:0] diff;
		diff = addr - mmd_pkg::WAKE_STATION_FIRST;
		station_index = diff[1:0];
	endfunction

	// ----------------------------------------------------------------
	// management frame slave
	// ----------------------------------------------------------------
	mgmt_frame_slave #(
		.PHY_ADDR(PHY_ADDR)
	) u_frame (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.rd_data(rd_data),
		.reg_addr(reg_addr),
		.wr_data(wr_data),
		.wr_stb(wr_stb),
		.rd_stb(rd_stb),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe)
	);

	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	// only the two portal offsets are mapped; the indirect spaces have no other path in
	assign ctrl_wr = wr_stb && reg_addr == mmd_pkg::REG_MMD_CONTROL;
	assign data_wr = wr_stb && reg_addr == mmd_pkg::REG_MMD_DATA; // [R01]
	assign data_rd = rd_stb && reg_addr == mmd_pkg::REG_MMD_DATA;
	assign data_mode = ctrl_op != mmd_pkg::OP_REGISTER; // [R03]
	assign ind_wr = data_wr && data_mode; // [R05]
	assign ind_rd = data_rd && data_mode;
	// mode 10 steps on both directions, mode 11 only on writes, mode 01 never
	assign advance = (ind_rd && ctrl_op == mmd_pkg::OP_DATA_INC_RW) // [R06]
		|| (ind_wr && (ctrl_op == mmd_pkg::OP_DATA_INC_RW || ctrl_op == mmd_pkg::OP_DATA_INC_WR)); // [R07] [R08]

	// ----------------------------------------------------------------
	// portal control register
	// ----------------------------------------------------------------
	// reserved bits are kept as plain storage and read back as written
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_op <= mmd_pkg::CTRL_RESET[mmd_pkg::CTRL_OP_MSB:mmd_pkg::CTRL_OP_LSB];
			ctrl_rsv <= mmd_pkg::CTRL_RESET[mmd_pkg::CTRL_RSV_MSB:mmd_pkg::CTRL_RSV_LSB];
			ctrl_dev <= mmd_pkg::CTRL_RESET[mmd_pkg::CTRL_DEV_MSB:0];
		end else if (ctrl_wr) begin
			ctrl_op <= wr_data[mmd_pkg::CTRL_OP_MSB:mmd_pkg::CTRL_OP_LSB]; // [R03]
			ctrl_rsv <= wr_data[mmd_pkg::CTRL_RSV_MSB:mmd_pkg::CTRL_RSV_LSB];
			ctrl_dev <= wr_data[mmd_pkg::CTRL_DEV_MSB:0]; // [R02]
		end
	end

	// ----------------------------------------------------------------
	// stored target register address
	// ----------------------------------------------------------------
	// the address wraps at the top of the space rather than saturating
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			portal_addr <= mmd_pkg::PORTAL_RESET;
		end else if (data_wr && !data_mode) begin
			portal_addr <= wr_data; // [R04] [R09]
		end else if (advance) begin
			portal_addr <= portal_addr + 16'h0001; // [R07] [R08] [R10]
		end
	end

	// ----------------------------------------------------------------
	// indirect space 1: line side control
	// ----------------------------------------------------------------
	// only the idle enable bit is stored; the rest of the word reads zero
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			low_power_idle_enable <= 1'b0;
		end else if (ind_wr && ctrl_dev == mmd_pkg::DEV_LINE_SIDE
			&& portal_addr == mmd_pkg::LINE_CONTROL_ONE) begin
			low_power_idle_enable <= wr_data[mmd_pkg::IDLE_ENABLE_BIT]; // [R13]
		end
	end

	// ----------------------------------------------------------------
	// idle entry latch
	// ----------------------------------------------------------------
	// the line side state arrives from another domain, so it is synchronised first
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			idle_s1 <= 1'b0;
			idle_s2 <= 1'b0;
		end else begin
			idle_s1 <= low_power_idle_state_in;
			idle_s2 <= idle_s1;
		end
	end

	// an entry seen in the same cycle as the clearing read wins, so no entry is lost
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			low_power_idle_latched <= 1'b0;
		end else if (idle_s2) begin
			low_power_idle_latched <= 1'b1; // [R14]
		end else if (ind_rd && ctrl_dev == mmd_pkg::DEV_LINE_SIDE
			&& portal_addr == mmd_pkg::LINE_STATUS_ONE) begin
			low_power_idle_latched <= 1'b0; // [R14]
		end
	end

	// ----------------------------------------------------------------
	// indirect space 1Fh: wake control and station address
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			wake_ctrl <= mmd_pkg::WAKE_RESET;
			wake_link_up_enable <= 1'b0;
		end else if (ind_wr && ctrl_dev == mmd_pkg::DEV_WAKE && portal_addr == mmd_pkg::WAKE_CONTROL) begin
			wake_ctrl <= wr_data;
			wake_link_up_enable <= wr_data[mmd_pkg::WAKE_LINK_UP_BIT]; // [R11]
		end
	end

	// three words held as an array so a burst walks them in address order
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < 3; i++) begin
				station_word[i] <= mmd_pkg::WAKE_RESET;
			end
		end else if (ind_wr && ctrl_dev == mmd_pkg::DEV_WAKE && station_hit(portal_addr)) begin
			station_word[station_index(portal_addr)] <= wr_data; // [R12]
		end
	end

	// ----------------------------------------------------------------
	// indirect read mux
	// ----------------------------------------------------------------
	// anything not decoded here reads zero; writes to it fall through untouched
	always_comb begin
		mmd_data = 16'h0000; // [R15]
		if (ctrl_dev == mmd_pkg::DEV_LINE_SIDE) begin
			if (portal_addr == mmd_pkg::LINE_CONTROL_ONE) begin
				mmd_data[mmd_pkg::IDLE_ENABLE_BIT] = low_power_idle_enable; // [R13]
			end else if (portal_addr == mmd_pkg::LINE_STATUS_ONE) begin
				mmd_data[mmd_pkg::IDLE_LATCHED_BIT] = low_power_idle_latched; // [R14]
			end
		end else if (ctrl_dev == mmd_pkg::DEV_WAKE) begin
			if (portal_addr == mmd_pkg::WAKE_CONTROL) begin
				mmd_data = wake_ctrl;
			end else if (station_hit(portal_addr)) begin
				mmd_data = station_word[station_index(portal_addr)]; // [R12]
			end
		end
	end

	// the frame slave copies this word in the cycle of its read strobe
	always_comb begin
		rd_data = 16'h0000;
		if (reg_addr == mmd_pkg::REG_MMD_CONTROL) begin
			rd_data = {ctrl_op, ctrl_rsv, ctrl_dev};
		end else if (reg_addr == mmd_pkg::REG_MMD_DATA) begin
			rd_data = data_mode ? mmd_data : portal_addr; // [R04] [R05]
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!nrst);

	sequence ctrl_write_s;
		wr_stb && reg_addr == mmd_pkg::REG_MMD_CONTROL;
	endsequence

	sequence data_read_s(logic [1:0] op);
		rd_stb && reg_addr == mmd_pkg::REG_MMD_DATA && ctrl_op == op;
	endsequence

	sequence data_write_s(logic [1:0] op);
		wr_stb && reg_addr == mmd_pkg::REG_MMD_DATA && ctrl_op == op;
	endsequence

	// a data-mode read of the status word while the line is out of idle
	sequence status_clear_s;
		ind_rd && ctrl_dev == mmd_pkg::DEV_LINE_SIDE
			&& portal_addr == mmd_pkg::LINE_STATUS_ONE && !idle_s2;
	endsequence

	// control writes land in the fields they name
	AST_DEVICE_SELECT: assert property (ctrl_write_s |=> ctrl_dev == $past(wr_data[4:0])) // [R02]
		else $error("device address not taken from control write");
	AST_OP_SELECT: assert property (ctrl_write_s |=> ctrl_op == $past(wr_data[15:14])) // [R03]
		else $error("operation not taken from control write");

	// address mode stores the target and never steps it
	AST_ADDR_STORE: assert property (data_write_s(mmd_pkg::OP_REGISTER) |=> portal_addr == $past(wr_data)) // [R04]
		else $error("stored target address not taken from data write");
	AST_ADDR_MODE_READ: assert property (data_read_s(mmd_pkg::OP_REGISTER) |=> $stable(portal_addr)) // [R04]
		else $error("address moved on an address mode read");

	// post-increment behaviour of the three data modes
	AST_HOLD_MODE: assert property ( // [R06]
		(data_read_s(mmd_pkg::OP_DATA_HOLD) or data_write_s(mmd_pkg::OP_DATA_HOLD)) |=> $stable(portal_addr))
		else $error("address moved in hold mode");
	AST_INC_BOTH: assert property ( // [R07] [R10]
		(data_read_s(mmd_pkg::OP_DATA_INC_RW) or data_write_s(mmd_pkg::OP_DATA_INC_RW))
		|=> portal_addr == $past(portal_addr) + 16'h0001)
		else $error("address did not step after access");
	AST_INC_WRITE_ONLY: assert property (data_write_s(mmd_pkg::OP_DATA_INC_WR) // [R08]
		|=> portal_addr == $past(portal_addr) + 16'h0001)
		else $error("address did not step after write");
	AST_NO_INC_ON_READ: assert property (data_read_s(mmd_pkg::OP_DATA_INC_WR) |=> $stable(portal_addr)) // [R08]
		else $error("address stepped after read in write-step mode");

	// indirect registers of the wake space
	AST_WAKE_ENABLE: assert property ( // [R11]
		ind_wr && ctrl_dev == mmd_pkg::DEV_WAKE && portal_addr == mmd_pkg::WAKE_CONTROL
		|=> wake_link_up_enable == $past(wr_data[mmd_pkg::WAKE_LINK_UP_BIT]) && wake_ctrl == $past(wr_data))
		else $error("wake control not written");
	AST_STATION_WRITE: assert property ( // [R12]
		ind_wr && ctrl_dev == mmd_pkg::DEV_WAKE && portal_addr == mmd_pkg::WAKE_STATION_FIRST
		|=> station_word[0] == $past(wr_data))
		else $error("first station word not written");
	AST_STATION_READ: assert property ( // [R12]
		ind_rd && ctrl_dev == mmd_pkg::DEV_WAKE && portal_addr == mmd_pkg::WAKE_STATION_FIRST
		|-> rd_data == station_word[0])
		else $error("first station word not returned");

	// line side idle enable and entry latch
	AST_IDLE_ENABLE: assert property ( // [R13]
		ind_wr && ctrl_dev == mmd_pkg::DEV_LINE_SIDE && portal_addr == mmd_pkg::LINE_CONTROL_ONE
		|=> low_power_idle_enable == $past(wr_data[mmd_pkg::IDLE_ENABLE_BIT]))
		else $error("idle enable not written");
	// the set side must win even in the cycle of a clearing read
	AST_IDLE_LATCH: assert property (idle_s2 |=> low_power_idle_latched) // [R14]
		else $error("idle entry not latched");
	AST_IDLE_CLEAR: assert property (status_clear_s |=> !low_power_idle_latched) // [R14]
		else $error("idle latch not cleared by status read");

	// unimplemented spaces read zero and take no writes
	AST_UNMAPPED_ZERO: assert property ( // [R15]
		ind_rd && ctrl_dev != mmd_pkg::DEV_LINE_SIDE && ctrl_dev != mmd_pkg::DEV_WAKE |-> rd_data == 16'h0000)
		else $error("unmapped space read nonzero");
	AST_UNMAPPED_WRITE: assert property ( // [R15]
		ind_wr && ctrl_dev != mmd_pkg::DEV_LINE_SIDE && ctrl_dev != mmd_pkg::DEV_WAKE
		|=> $stable(wake_ctrl) && $stable(low_power_idle_enable))
		else $error("unmapped space write had a side effect");

endmodule

// >>> dv/mgmt_manager_model.sv
// management manager model: drives the management clock and data pin
`timescale 1ns/1ps
module mgmt_manager_model (
	input wire logic sys_clk,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	output logic mdc,
	output logic mdio_in
);
	logic m_bit;
	logic m_oe;

	// pulled-up pin: a released line reads high, never the last driven value
	assign mdio_in = mdio_oe ? mdio_out : (m_oe ? m_bit : 1'b1);

	initial begin
		mdc = 1'b0;
		m_bit = 1'b1;
		m_oe = 1'b0;
	end

	// one bit time of 8 system cycles: data changes with the clock low, pin sampled just before the rise
	task automatic tick(input logic drv, input logic b, output logic s);
		@(negedge sys_clk);
		mdc = 1'b0;
		m_oe = drv;
		m_bit = b;
		repeat (4) @(negedge sys_clk);
		s = mdio_in;
		mdc = 1'b1;
		repeat (3) @(negedge sys_clk);
	endtask

	// whole frame; the clock stands still low afterwards so the device can drop its drive
	task automatic xfer(input logic [4:0] phy, input logic rd, input logic [4:0] ra, input logic [15:0] wd,
		output logic [15:0] rdat);
		logic [17:0] hdr;
		logic s;
		hdr = {4'hF, 2'h1, (rd ? mmd_pkg::FRAME_OP_READ : mmd_pkg::FRAME_OP_WRITE), phy, ra};
		for (int i = 17; i >= 0; i--) begin
			tick(1'b1, hdr[i], s);
		end
		tick(!rd, 1'b1, s);
		tick(!rd, 1'b0, s);
		for (int i = 15; i >= 0; i--) begin
			tick(!rd, wd[i], s);
			rdat[i] = s;
		end
		@(negedge sys_clk);
		mdc = 1'b0;
		m_oe = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask
endmodule

// >>> dv/tb_mmd_indirect_portal.sv
// self-checking bench for the indirect register portal
`timescale 1ns/1ps
module tb_mmd_indirect_portal;
	localparam logic [4:0] PHY = 5'h03;
	localparam int CEIL = 30000;
	logic sys_clk, nrst, mdc, mdio_in, low_power_idle_state_in, mdio_out, mdio_oe, idle_en, wake_en;
	int fails = 0;
	int tests_run = 0;
	int cycles = 0;

	mmd_indirect_portal #(.PHY_ADDR(PHY)) i_mmd_indirect_portal (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.mdc(mdc),
		.mdio_in(mdio_in),
		.low_power_idle_state_in(low_power_idle_state_in),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.low_power_idle_enable(idle_en),
		.wake_link_up_enable(wake_en)
	);

	mgmt_manager_model i_mgmt_manager_model (
		.sys_clk(sys_clk),
		.mdio_out(mdio_out),
		.mdio_oe(mdio_oe),
		.mdc(mdc),
		.mdio_in(mdio_in)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] x;
		i_mgmt_manager_model.xfer(PHY, 1'b0, ra, d, x);
	endtask

	task automatic rdchk(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] v;
		i_mgmt_manager_model.xfer(PHY, 1'b1, ra, 16'h0000, v);
		check(v, exp);
		check({15'h0000, mdio_oe}, 16'h0000);
	endtask

	// address mode first, then the data mode: the order a manager must
	task automatic point(input logic [4:0] dev, input logic [15:0] ra, input logic [1:0] op);
		wr(mmd_pkg::REG_MMD_CONTROL, {mmd_pkg::OP_REGISTER, 9'h000, dev});
		wr(mmd_pkg::REG_MMD_DATA, ra);
		wr(mmd_pkg::REG_MMD_CONTROL, {op, 9'h000, dev});
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic reset_values();
		check({14'h0000, idle_en, wake_en}, 16'h0000);
		rdchk(mmd_pkg::REG_MMD_CONTROL, mmd_pkg::CTRL_RESET);
		rdchk(mmd_pkg::REG_MMD_DATA, mmd_pkg::PORTAL_RESET);
	endtask

	task automatic wake_write();
		point(mmd_pkg::DEV_WAKE, mmd_pkg::WAKE_CONTROL, mmd_pkg::OP_DATA_HOLD);
		wr(mmd_pkg::REG_MMD_DATA, 16'h0001);
		check({15'h0000, wake_en}, 16'h0001);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h0001);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h0001);
		wr(mmd_pkg::REG_MMD_CONTROL, {mmd_pkg::OP_REGISTER, 9'h000, mmd_pkg::DEV_WAKE});
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h0000);
	endtask

	// station words written with write-only stepping, then read back as a burst
	task automatic station_burst();
		point(mmd_pkg::DEV_WAKE, mmd_pkg::WAKE_STATION_FIRST, mmd_pkg::OP_DATA_INC_WR);
		for (int i = 0; i < 3; i++) begin
			wr(mmd_pkg::REG_MMD_DATA, 16'hA5A0 + 16'(i));
		end
		wr(mmd_pkg::REG_MMD_CONTROL, {mmd_pkg::OP_REGISTER, 9'h000, mmd_pkg::DEV_WAKE});
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h001C);
		point(mmd_pkg::DEV_WAKE, mmd_pkg::WAKE_STATION_FIRST, mmd_pkg::OP_DATA_INC_WR);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'hA5A0);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'hA5A0);
		point(mmd_pkg::DEV_WAKE, mmd_pkg::WAKE_STATION_FIRST, mmd_pkg::OP_DATA_INC_RW);
		for (int i = 0; i < 3; i++) begin
			rdchk(mmd_pkg::REG_MMD_DATA, 16'hA5A0 + 16'(i));
		end
		wr(mmd_pkg::REG_MMD_CONTROL, {mmd_pkg::OP_REGISTER, 9'h000, mmd_pkg::DEV_WAKE});
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h001C);
	endtask

	task automatic idle_bits();
		point(mmd_pkg::DEV_LINE_SIDE, mmd_pkg::LINE_CONTROL_ONE, mmd_pkg::OP_DATA_HOLD);
		wr(mmd_pkg::REG_MMD_DATA, 16'h1000);
		check({15'h0000, idle_en}, 16'h0001);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h1000);
		point(mmd_pkg::DEV_LINE_SIDE, mmd_pkg::LINE_STATUS_ONE, mmd_pkg::OP_DATA_HOLD);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h0000);
		// short idle visit: the latch must keep it after the line leaves idle
		@(negedge sys_clk);
		low_power_idle_state_in = 1'b1;
		repeat (10) @(negedge sys_clk);
		low_power_idle_state_in = 1'b0;
		repeat (10) @(negedge sys_clk);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h0100);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h0000);
	endtask

	task automatic refusals();
		logic [15:0] x;
		point(5'h05, 16'h0000, mmd_pkg::OP_DATA_HOLD);
		wr(mmd_pkg::REG_MMD_DATA, 16'hBEEF);
		rdchk(mmd_pkg::REG_MMD_DATA, 16'h0000);
		check({14'h0000, idle_en, wake_en}, 16'h0003);
		rdchk(5'h03, 16'h0000);
		for (int op = 0; op < 4; op++) begin
			wr(mmd_pkg::REG_MMD_CONTROL, {2'(op), 9'h155, 5'h0A});
			rdchk(mmd_pkg::REG_MMD_CONTROL, {2'(op), 9'h155, 5'h0A});
		end
		i_mgmt_manager_model.xfer(PHY ^ 5'h01, 1'b0, mmd_pkg::REG_MMD_CONTROL, 16'h0000, x);
		rdchk(mmd_pkg::REG_MMD_CONTROL, {2'h3, 9'h155, 5'h0A});
	endtask

	// ----------------------------------------------------------------
	// clock, reset, sequence and hang guard
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == CEIL) begin
			fails++;
			summarize();
		end
	end

	initial begin
		nrst = 1'b0;
		low_power_idle_state_in = 1'b0;
		repeat (3) @(negedge sys_clk);
		nrst = 1'b1;
		repeat (5) @(negedge sys_clk);
		reset_values();
		wake_write();
		station_burst();
		idle_bits();
		refusals();
		summarize();
	end
endmodule
